//--- flash_guard_pkg.sv
// Shared constants, types and helpers for the flash access guard
package flash_guard_pkg;

  // ==========
  // Widths
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int PAGE_LSB = 10;
  localparam int LIMIT_LSB = 9;

  // ==========
  // Register offsets
  localparam logic [7:0] STORE_ADDR = 8'h8f;
  localparam logic [7:0] CTRL_ADDR = 8'hb7;
  localparam logic [7:0] LIMIT_ADDR = 8'hb6;

  // ==========
  // Reset values, writable and reserved bit masks
  localparam logic [7:0] STORE_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h80;
  localparam logic [7:0] LIMIT_RESET = 8'h00;
  localparam logic [7:0] STORE_WMASK = 8'h07;
  localparam logic [7:0] CTRL_WMASK = 8'hf1;
  localparam logic [7:0] CTRL_RSVD_MASK = 8'h0e;

  // ==========
  // Field positions
  localparam int PWE_BIT = 0;
  localparam int PEE_BIT = 1;
  localparam int SCR_BIT = 2;
  localparam int FWE_BIT = 0;
  localparam int FRT_LSB = 4;
  localparam int FRT_MSB = 5;

  // ==========
  // Memory map
  localparam logic [16:0] SECURITY_PAGE_BASE = 17'h1_f800;
  localparam logic [16:0] RESERVED_BASE = 17'h1_fc00;
  localparam logic [16:0] SCRATCH_MAX = 17'h0_00ff;
  localparam logic [16:0] SCRATCH_ERASE_ALL = 17'h0_0400;
  localparam logic [7:0] DENY_DATA = 8'h00;

  // ==========
  // Types
  typedef enum logic [1:0] {
    MEM_FETCH = 2'b00,
    MEM_CODE_READ = 2'b01,
    MEM_DATA_WRITE = 2'b10
  } mem_op_t;

  typedef enum logic [1:0] {
    FL_READ = 2'b00,
    FL_PROG = 2'b01,
    FL_ERASE = 2'b10
  } flash_op_t;

  typedef enum logic [2:0] {
    CMD_SFR_WRITE = 3'b000,
    CMD_SFR_READ = 3'b001,
    CMD_CODE_READ = 3'b010,
    CMD_DATA_WRITE = 3'b011,
    CMD_FETCH = 3'b100
  } cmd_kind_t;

  function automatic logic [6:0] page_of(input logic [16:0] addr);
    page_of = addr[16:PAGE_LSB];
  endfunction : page_of

endpackage : flash_guard_pkg

//--- flash_guard_if.sv
// Interface joining the processor core end and the flash guard end
interface flash_guard_if;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic sfr_ack;
  logic mem_req;
  flash_guard_pkg::mem_op_t mem_op;
  logic [16:0] mem_addr;
  logic [16:0] exec_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic mem_ack;
  logic mem_denied;

  modport device (
    input sfr_wr, sfr_rd, sfr_addr, sfr_wdata, mem_req, mem_op, mem_addr, exec_addr, mem_wdata,
    output sfr_rdata, sfr_ack, mem_rdata, mem_ack, mem_denied
  );

  modport host (
    output sfr_wr, sfr_rd, sfr_addr, sfr_wdata, mem_req, mem_op, mem_addr, exec_addr, mem_wdata,
    input sfr_rdata, sfr_ack, mem_rdata, mem_ack, mem_denied
  );
endinterface : flash_guard_if

//--- flash_access_check.sv
// Permission decision for one firmware flash access
module flash_access_check (
  input wire flash_guard_pkg::flash_op_t op_in,
  input wire logic [16:0] addr_in,
  input wire logic [16:0] exec_addr_in,
  input wire logic [16:0] limit_in,
  input wire logic write_erase_enable_in,
  input wire logic scratch_in,
  output logic allow_out
);
  logic upper;
  logic is_write;

  always_comb begin
    upper = (exec_addr_in >= limit_in);
    is_write = (op_in != flash_guard_pkg::FL_READ);
    allow_out = 1'b1;
    if (scratch_in) begin
      allow_out = 1'b1;
    end else if (addr_in >= flash_guard_pkg::RESERVED_BASE) begin
      allow_out = 1'b0;
    end else if (op_in == flash_guard_pkg::FL_ERASE &&
                 flash_guard_pkg::page_of(addr_in) == flash_guard_pkg::page_of(flash_guard_pkg::SECURITY_PAGE_BASE)) begin
      allow_out = 1'b0;
    end else if (upper && addr_in < limit_in) begin
      allow_out = 1'b0;
    end
    if (is_write && !write_erase_enable_in) begin
      allow_out = 1'b0;
    end
  end
endmodule : flash_access_check

//--- flash_access_guard.sv
// Flash access guard: control registers, access decision and flash sequencing
// Contract
// - Debug lock bytes never gate firmware accesses
// - Lower code accesses all but reserved area
// - Firmware erase of security page refused
// - Firmware may read, write security page
// - Reserved area always blocked; instruction fetches there are not checked and still reach flash
// - Upper code accesses only upper pages
// - Upper code refused on lower pages
// - Instruction fetch below limit always allowed
// - Read time field bits 5-4 selects timing
// - Control bits 3-1 read zero, write zero
// - Write enable bit 0 gates writes, erases
// - Software quiets cache before lowering read time
// - Scratchpad select routes reads, writes to scratchpad
// - Scratchpad addresses 0x00-0xFF; 0x400 erases both
// - Erase enable plus write enable erases page
// - Write enable: flash byte, else external RAM
// - Software erases before programming a byte
// - Store control bits 7-3 read zero
// - Limit is register high bits, write-once
// - Upper code reads of lower give junk; refused reads here return fixed 0x00
module flash_access_guard (
  input wire logic clk_in,
  input wire logic resetn_in,
  flash_guard_if.device bus,
  input wire logic flash_done_in,
  input wire logic [7:0] flash_rdata_in,
  output logic flash_start_out,
  output flash_guard_pkg::flash_op_t flash_op_out,
  output logic [16:0] flash_addr_out,
  output logic [7:0] flash_wdata_out,
  output logic flash_scratch_out,
  output logic flash_erase_both_out,
  output logic [1:0] flash_read_time_out,
  output logic xram_wr_out,
  output logic [15:0] xram_addr_out,
  output logic [7:0] xram_wdata_out
);

  typedef enum logic {
    DS_IDLE = 1'b0,
    DS_FLASH = 1'b1
  } dev_state_t;

  // ==========
  // Control registers
  logic [7:0] program_store_control, next_program_store_control;
  logic [7:0] flash_memory_control, next_flash_memory_control;
  logic [7:0] access_limit_register, next_access_limit_register;
  logic [7:0] sfr_rdata, next_sfr_rdata;
  logic limit_written, next_limit_written, sfr_ack, next_sfr_ack;

  always_comb begin
    next_program_store_control = program_store_control;
    next_flash_memory_control = flash_memory_control;
    next_access_limit_register = access_limit_register;
    next_limit_written = limit_written;
    next_sfr_ack = bus.sfr_wr | bus.sfr_rd;
    next_sfr_rdata = 8'h00;
    if (bus.sfr_wr) begin
      unique case (bus.sfr_addr)
        flash_guard_pkg::STORE_ADDR:
          next_program_store_control = bus.sfr_wdata & flash_guard_pkg::STORE_WMASK;
        flash_guard_pkg::CTRL_ADDR:
          next_flash_memory_control = bus.sfr_wdata & flash_guard_pkg::CTRL_WMASK;
        flash_guard_pkg::LIMIT_ADDR: begin
          if (!limit_written) begin
            next_access_limit_register = bus.sfr_wdata;
            next_limit_written = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (bus.sfr_rd) begin
      unique case (bus.sfr_addr)
        flash_guard_pkg::STORE_ADDR: next_sfr_rdata = program_store_control;
        flash_guard_pkg::CTRL_ADDR: next_sfr_rdata = flash_memory_control;
        flash_guard_pkg::LIMIT_ADDR: next_sfr_rdata = access_limit_register;
        default: next_sfr_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      program_store_control <= flash_guard_pkg::STORE_RESET;
      flash_memory_control <= flash_guard_pkg::CTRL_RESET;
      access_limit_register <= flash_guard_pkg::LIMIT_RESET;
      limit_written <= 1'b0;
      sfr_rdata <= 8'h00;
      sfr_ack <= 1'b0;
    end else begin
      program_store_control <= next_program_store_control;
      flash_memory_control <= next_flash_memory_control;
      access_limit_register <= next_access_limit_register;
      limit_written <= next_limit_written;
      sfr_rdata <= next_sfr_rdata;
      sfr_ack <= next_sfr_ack;
    end
  end

  assign bus.sfr_rdata = sfr_rdata;
  assign bus.sfr_ack = sfr_ack;

  // ==========
  // Access decision
  logic [16:0] access_limit_address;
  logic scratchpad_select;
  logic program_write_enable;
  logic page_erase_enable;
  flash_guard_pkg::flash_op_t req_op;
  logic allow;

  assign access_limit_address = {access_limit_register, {flash_guard_pkg::LIMIT_LSB{1'b0}}};
  assign scratchpad_select = program_store_control[flash_guard_pkg::SCR_BIT];
  assign program_write_enable = program_store_control[flash_guard_pkg::PWE_BIT];
  assign page_erase_enable = program_store_control[flash_guard_pkg::PEE_BIT];

  always_comb begin
    req_op = flash_guard_pkg::FL_READ;
    if (bus.mem_op == flash_guard_pkg::MEM_DATA_WRITE) begin
      req_op = page_erase_enable ? flash_guard_pkg::FL_ERASE : flash_guard_pkg::FL_PROG;
    end
  end

  flash_access_check flash_access_check_inst (
    .op_in(req_op),
    .addr_in(bus.mem_addr),
    .exec_addr_in(bus.exec_addr),
    .limit_in(access_limit_address),
    .write_erase_enable_in(flash_memory_control[flash_guard_pkg::FWE_BIT]),
    .scratch_in(scratchpad_select),
    .allow_out(allow)
  );

  // ==========
  // Access sequencing
  dev_state_t state, next_state;
  logic mem_ack, next_mem_ack, mem_denied, next_mem_denied, flash_start, next_flash_start;
  logic flash_scratch, next_flash_scratch, flash_erase_both, next_flash_erase_both, xram_wr, next_xram_wr;
  logic [7:0] mem_rdata, next_mem_rdata, flash_wdata, next_flash_wdata, xram_wdata, next_xram_wdata;
  flash_guard_pkg::flash_op_t flash_op, next_flash_op;
  logic [16:0] flash_addr, next_flash_addr;
  logic [15:0] xram_addr, next_xram_addr;

  always_comb begin
    next_state = state;
    next_mem_ack = 1'b0;
    next_mem_denied = mem_denied;
    next_mem_rdata = mem_rdata;
    next_flash_start = 1'b0;
    next_flash_op = flash_op;
    next_flash_addr = flash_addr;
    next_flash_wdata = flash_wdata;
    next_flash_scratch = flash_scratch;
    next_flash_erase_both = flash_erase_both;
    next_xram_wr = 1'b0;
    next_xram_addr = xram_addr;
    next_xram_wdata = xram_wdata;
    unique case (state)
      DS_IDLE: begin
        if (bus.mem_req) begin
          next_flash_addr = bus.mem_addr;
          next_flash_wdata = bus.mem_wdata;
          next_flash_op = req_op;
          next_flash_scratch = scratchpad_select && bus.mem_op != flash_guard_pkg::MEM_FETCH;
          // erase at 0x400 clears both sectors
          next_flash_erase_both = scratchpad_select && req_op == flash_guard_pkg::FL_ERASE &&
                                  bus.mem_addr == flash_guard_pkg::SCRATCH_ERASE_ALL;
          next_mem_denied = 1'b0;
          if (bus.mem_op == flash_guard_pkg::MEM_FETCH) begin
            next_flash_op = flash_guard_pkg::FL_READ;
            next_flash_scratch = 1'b0;
            next_flash_start = 1'b1;
            next_state = DS_FLASH;
          end else if (bus.mem_op == flash_guard_pkg::MEM_DATA_WRITE && !program_write_enable) begin
            // writes fall through to external RAM
            next_xram_wr = 1'b1;
            next_xram_addr = bus.mem_addr[15:0];
            next_xram_wdata = bus.mem_wdata;
            next_mem_ack = 1'b1;
          end else if (allow) begin
            next_flash_start = 1'b1;
            next_state = DS_FLASH;
          end else begin
            // refused: no flash cycle, fixed data
            next_mem_rdata = flash_guard_pkg::DENY_DATA;
            next_mem_denied = 1'b1;
            next_mem_ack = 1'b1;
          end
        end
      end
      DS_FLASH: begin
        // Flash macro is slow; hold the request until it reports done
        if (flash_done_in) begin
          next_mem_rdata = (flash_op == flash_guard_pkg::FL_READ) ? flash_rdata_in : 8'h00;
          next_mem_ack = 1'b1;
          next_state = DS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state <= DS_IDLE;
      mem_ack <= 1'b0;
      mem_denied <= 1'b0;
      mem_rdata <= 8'h00;
      flash_start <= 1'b0;
      flash_op <= flash_guard_pkg::FL_READ;
      flash_addr <= 17'h0_0000;
      flash_wdata <= 8'h00;
      flash_scratch <= 1'b0;
      flash_erase_both <= 1'b0;
      xram_wr <= 1'b0;
      xram_addr <= 16'h0000;
      xram_wdata <= 8'h00;
    end else begin
      state <= next_state;
      mem_ack <= next_mem_ack;
      mem_denied <= next_mem_denied;
      mem_rdata <= next_mem_rdata;
      flash_start <= next_flash_start;
      flash_op <= next_flash_op;
      flash_addr <= next_flash_addr;
      flash_wdata <= next_flash_wdata;
      flash_scratch <= next_flash_scratch;
      flash_erase_both <= next_flash_erase_both;
      xram_wr <= next_xram_wr;
      xram_addr <= next_xram_addr;
      xram_wdata <= next_xram_wdata;
    end
  end

  assign bus.mem_ack = mem_ack;
  assign bus.mem_denied = mem_denied;
  assign bus.mem_rdata = mem_rdata;
  assign flash_start_out = flash_start;
  assign flash_op_out = flash_op;
  assign flash_addr_out = flash_addr;
  assign flash_wdata_out = flash_wdata;
  assign flash_scratch_out = flash_scratch;
  assign flash_erase_both_out = flash_erase_both;
  // read time straight from the field
  assign flash_read_time_out = flash_memory_control[flash_guard_pkg::FRT_MSB:flash_guard_pkg::FRT_LSB];
  assign xram_wr_out = xram_wr;
  assign xram_addr_out = xram_addr;
  assign xram_wdata_out = xram_wdata;

endmodule : flash_access_guard

//--- flash_core_port.sv
// Processor core end: turns user commands into register and flash requests
module flash_core_port (
  input wire logic clk_in,
  input wire logic resetn_in,
  flash_guard_if.host bus,
  input wire logic cmd_valid_in,
  input wire flash_guard_pkg::cmd_kind_t cmd_kind_in,
  input wire logic [16:0] cmd_addr_in,
  input wire logic [16:0] cmd_exec_in,
  input wire logic [7:0] cmd_data_in,
  output logic cmd_ready_out,
  output logic rsp_valid_out,
  output logic [7:0] rsp_data_out,
  output logic rsp_denied_out,
  output logic cache_quiet_out
);

  typedef enum logic {
    HS_IDLE = 1'b0,
    HS_WAIT = 1'b1
  } host_state_t;

  // ==========
  // Request issue and answer collection
  host_state_t state;
  host_state_t next_state;
  logic sfr_wr, sfr_rd, mem_req;
  logic next_sfr_wr, next_sfr_rd, next_mem_req;
  flash_guard_pkg::mem_op_t mem_op, next_mem_op;
  logic [7:0] req_addr8, next_req_addr8, wdata, next_wdata;
  logic [16:0] addr, next_addr, exec, next_exec;
  logic rsp_valid, next_rsp_valid, rsp_denied, next_rsp_denied;
  logic [7:0] rsp_data, next_rsp_data;
  logic scratch_shadow, next_scratch_shadow;
  logic [1:0] read_time_shadow, next_read_time_shadow;
  logic cache_quiet, next_cache_quiet;
  logic is_mem, out_of_scratch;
  logic [7:0] sfr_value;

  always_comb begin
    next_state = state;
    next_sfr_wr = 1'b0;
    next_sfr_rd = 1'b0;
    next_mem_req = 1'b0;
    next_mem_op = mem_op;
    next_req_addr8 = req_addr8;
    next_wdata = wdata;
    next_addr = addr;
    next_exec = exec;
    next_rsp_valid = 1'b0;
    next_rsp_denied = rsp_denied;
    next_rsp_data = rsp_data;
    next_scratch_shadow = scratch_shadow;
    next_read_time_shadow = read_time_shadow;
    next_cache_quiet = cache_quiet;
    is_mem = cmd_kind_in == flash_guard_pkg::CMD_CODE_READ || cmd_kind_in == flash_guard_pkg::CMD_DATA_WRITE;
    // scratchpad range is 0x00-0xFF, except erase-all
    out_of_scratch = scratch_shadow && is_mem && cmd_addr_in > flash_guard_pkg::SCRATCH_MAX &&
                     !(cmd_kind_in == flash_guard_pkg::CMD_DATA_WRITE &&
                       cmd_addr_in == flash_guard_pkg::SCRATCH_ERASE_ALL);
    // reserved control bits written as zero
    sfr_value = (cmd_addr_in[7:0] == flash_guard_pkg::CTRL_ADDR) ?
                (cmd_data_in & ~flash_guard_pkg::CTRL_RSVD_MASK) : cmd_data_in;
    unique case (state)
      HS_IDLE: begin
        if (cmd_valid_in) begin
          next_req_addr8 = cmd_addr_in[7:0];
          next_wdata = cmd_kind_in == flash_guard_pkg::CMD_SFR_WRITE ? sfr_value : cmd_data_in;
          next_addr = cmd_addr_in;
          next_exec = cmd_exec_in;
          if (out_of_scratch) begin
            // Refused locally; the result would be undefined anyway
            next_rsp_valid = 1'b1;
            next_rsp_denied = 1'b1;
            next_rsp_data = 8'h00;
          end else begin
            next_state = HS_WAIT;
            unique case (cmd_kind_in)
              flash_guard_pkg::CMD_SFR_WRITE: begin
                next_sfr_wr = 1'b1;
                if (cmd_addr_in[7:0] == flash_guard_pkg::STORE_ADDR) begin
                  next_scratch_shadow = cmd_data_in[flash_guard_pkg::SCR_BIT];
                end
                if (cmd_addr_in[7:0] == flash_guard_pkg::CTRL_ADDR) begin
                  // quiet the cache when read time drops
                  next_cache_quiet = sfr_value[flash_guard_pkg::FRT_MSB:flash_guard_pkg::FRT_LSB] < read_time_shadow;
                  next_read_time_shadow = sfr_value[flash_guard_pkg::FRT_MSB:flash_guard_pkg::FRT_LSB];
                end
              end
              flash_guard_pkg::CMD_SFR_READ: next_sfr_rd = 1'b1;
              flash_guard_pkg::CMD_CODE_READ: begin
                next_mem_req = 1'b1;
                next_mem_op = flash_guard_pkg::MEM_CODE_READ;
              end
              flash_guard_pkg::CMD_DATA_WRITE: begin
                next_mem_req = 1'b1;
                next_mem_op = flash_guard_pkg::MEM_DATA_WRITE;
              end
              flash_guard_pkg::CMD_FETCH: begin
                next_mem_req = 1'b1;
                next_mem_op = flash_guard_pkg::MEM_FETCH;
              end
              default: begin
                next_state = HS_IDLE;
                next_rsp_valid = 1'b1;
                next_rsp_denied = 1'b1;
              end
            endcase
          end
        end
      end
      HS_WAIT: begin
        if (bus.sfr_ack || bus.mem_ack) begin
          next_state = HS_IDLE;
          next_rsp_valid = 1'b1;
          next_rsp_data = bus.sfr_ack ? bus.sfr_rdata : bus.mem_rdata;
          next_rsp_denied = bus.mem_ack & bus.mem_denied;
          next_cache_quiet = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state <= HS_IDLE;
      sfr_wr <= 1'b0;
      sfr_rd <= 1'b0;
      mem_req <= 1'b0;
      mem_op <= flash_guard_pkg::MEM_FETCH;
      req_addr8 <= 8'h00;
      wdata <= 8'h00;
      addr <= 17'h0_0000;
      exec <= 17'h0_0000;
      rsp_valid <= 1'b0;
      rsp_denied <= 1'b0;
      rsp_data <= 8'h00;
      scratch_shadow <= 1'b0;
      read_time_shadow <= 2'h0;
      cache_quiet <= 1'b0;
    end else begin
      state <= next_state;
      sfr_wr <= next_sfr_wr;
      sfr_rd <= next_sfr_rd;
      mem_req <= next_mem_req;
      mem_op <= next_mem_op;
      req_addr8 <= next_req_addr8;
      wdata <= next_wdata;
      addr <= next_addr;
      exec <= next_exec;
      rsp_valid <= next_rsp_valid;
      rsp_denied <= next_rsp_denied;
      rsp_data <= next_rsp_data;
      scratch_shadow <= next_scratch_shadow;
      read_time_shadow <= next_read_time_shadow;
      cache_quiet <= next_cache_quiet;
    end
  end

  assign bus.sfr_wr = sfr_wr;
  assign bus.sfr_rd = sfr_rd;
  assign bus.sfr_addr = req_addr8;
  assign bus.sfr_wdata = wdata;
  assign bus.mem_req = mem_req;
  assign bus.mem_op = mem_op;
  assign bus.mem_addr = addr;
  assign bus.exec_addr = exec;
  assign bus.mem_wdata = wdata;
  assign cmd_ready_out = (state == HS_IDLE) && !rsp_valid;
  assign rsp_valid_out = rsp_valid;
  assign rsp_data_out = rsp_data;
  assign rsp_denied_out = rsp_denied;
  assign cache_quiet_out = cache_quiet;

endmodule : flash_core_port

//--- flash_guard_props.sv
// Checker for the interface between the core end and the flash guard end
module flash_guard_props (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_ack,
  input wire logic mem_req,
  input wire flash_guard_pkg::mem_op_t mem_op,
  input wire logic [16:0] mem_addr,
  input wire logic [16:0] exec_addr,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic mem_denied
);
  // ==========
  // Register shadows
  logic [7:0] ps, fl, acl;
  logic once, chk, ers;
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ps <= 8'h00;
      fl <= 8'h80;
      acl <= 8'h00;
      once <= 1'b0;
    end else if (sfr_wr) begin
      if (sfr_addr == flash_guard_pkg::STORE_ADDR) ps <= sfr_wdata;
      if (sfr_addr == flash_guard_pkg::CTRL_ADDR) fl <= sfr_wdata;
      if (sfr_addr == flash_guard_pkg::LIMIT_ADDR && !once) begin
        acl <= sfr_wdata;
        once <= 1'b1;
      end
    end
  end
  // Scratch and external RAM writes skip the checks
  assign chk = mem_req && !ps[2] && (mem_op == flash_guard_pkg::MEM_CODE_READ ||
    (mem_op == flash_guard_pkg::MEM_DATA_WRITE && ps[0]));
  assign ers = mem_op == flash_guard_pkg::MEM_DATA_WRITE && ps[1:0] == 2'b11;
  // ==========
  // Properties
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  AST_RSVD: assert property (chk && mem_addr >= 17'h1_fc00 |=> mem_ack && mem_denied)
    else $error("reserved area reached");
  AST_SEC_ERASE: assert property (chk && ers && mem_addr >= 17'h1_f800 |=> mem_ack && mem_denied)
    else $error("security page erased");
  AST_UPPER: assert property (chk && exec_addr >= {acl, 9'h000} && mem_addr < {acl, 9'h000}
    |=> mem_ack && mem_denied) else $error("lower page reached from upper code");
  AST_WE_GATE: assert property (mem_req && mem_op == flash_guard_pkg::MEM_DATA_WRITE && ps[0] && !fl[0]
    |=> mem_ack && mem_denied) else $error("write without enable");
  AST_LOWER_OK: assert property (chk && mem_op == flash_guard_pkg::MEM_CODE_READ && exec_addr < {acl, 9'h000}
    && mem_addr < 17'h1_fc00 |=> !mem_ack) else $error("lower code read refused");
  AST_FETCH: assert property (mem_req && mem_op == flash_guard_pkg::MEM_FETCH |-> ##[2:40] mem_ack && !mem_denied)
    else $error("fetch refused");
  AST_DENY_DATA: assert property (mem_ack && mem_denied |-> mem_rdata == 8'h00)
    else $error("refused read leaks data");
  AST_FLASH_MEMORY_CONTROL_RSVD: assert property (sfr_ack && sfr_addr == 8'hb7 |-> sfr_rdata[3:1] == 3'b000)
    else $error("reserved control bits set");
  AST_PROGRAM_STORE_CONTROL_RSVD: assert property (sfr_ack && sfr_addr == 8'h8f |-> sfr_rdata[7:3] == 5'h00)
    else $error("unused store bits set");
endmodule : flash_guard_props

//--- flash_access_guard_bench.sv
// Testbench joining both ends of the flash guard
module flash_access_guard_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic cmd_valid = 1'b0;
  flash_guard_pkg::cmd_kind_t cmd_kind = flash_guard_pkg::CMD_SFR_READ;
  logic [16:0] cmd_addr = 17'h0_0000, cmd_exec = 17'h0_0000, f_addr, last_addr, a, e;
  logic [7:0] cmd_data = 8'h00, flash_rdata = 8'h00, rsp_data, x_data, f_data;
  logic [15:0] x_addr;
  logic quiet;
  logic flash_done = 1'b0, cmd_ready, rsp_valid, rsp_denied, f_start, f_scr, f_both, xram_wr, last_scr, last_both;
  flash_guard_pkg::flash_op_t f_op, last_op;
  logic [1:0] rtime;
  logic [31:0] seed = 32'h289f_8252;
  int n_errors = 0, n_compared = 0, n_starts = 0, n_xram = 0, n_quiet = 0, s;
  flash_guard_if bus_if();
  flash_access_guard flash_access_guard_inst (.clk_in(clk_in), .resetn_in(resetn_in), .bus(bus_if.device),
    .flash_done_in(flash_done), .flash_rdata_in(flash_rdata), .flash_start_out(f_start), .flash_op_out(f_op),
    .flash_addr_out(f_addr), .flash_wdata_out(f_data), .flash_scratch_out(f_scr), .flash_erase_both_out(f_both),
    .flash_read_time_out(rtime), .xram_wr_out(xram_wr), .xram_addr_out(x_addr), .xram_wdata_out(x_data));
  flash_core_port flash_core_port_inst (.clk_in(clk_in), .resetn_in(resetn_in), .bus(bus_if.host),
    .cmd_valid_in(cmd_valid), .cmd_kind_in(cmd_kind), .cmd_addr_in(cmd_addr), .cmd_exec_in(cmd_exec),
    .cmd_data_in(cmd_data), .cmd_ready_out(cmd_ready), .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data),
    .rsp_denied_out(rsp_denied), .cache_quiet_out(quiet));
  flash_guard_props flash_guard_props_inst (.clk_in(clk_in), .resetn_in(resetn_in), .sfr_wr(bus_if.sfr_wr),
    .sfr_addr(bus_if.sfr_addr), .sfr_wdata(bus_if.sfr_wdata), .sfr_rdata(bus_if.sfr_rdata),
    .sfr_ack(bus_if.sfr_ack), .mem_req(bus_if.mem_req), .mem_op(bus_if.mem_op), .mem_addr(bus_if.mem_addr),
    .exec_addr(bus_if.exec_addr), .mem_rdata(bus_if.mem_rdata), .mem_ack(bus_if.mem_ack),
    .mem_denied(bus_if.mem_denied));
  initial forever #10 clk_in = ~clk_in;
  // ==========
  // Flash macro stand-in, answering after a random delay
  always @(negedge clk_in) begin
    if (xram_wr) n_xram++;
    if (quiet) n_quiet++;
    if (f_start) begin
      n_starts++;
      last_op = f_op;
      last_addr = f_addr;
      last_scr = f_scr;
      last_both = f_both;
      repeat (1 + seed[1:0]) @(negedge clk_in);
      flash_rdata = last_addr[7:0] ^ 8'h5a;
      flash_done = 1'b1;
      @(negedge clk_in);
      flash_done = 1'b0;
      // Inverted on release so stale data is not mistaken
      flash_rdata = ~flash_rdata;
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  // ==========
  // Tasks
  task automatic stop_test;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cmd(input logic [2:0] k, input logic [16:0] ad, input logic [16:0] ex, input logic [7:0] d);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd_kind = flash_guard_pkg::cmd_kind_t'(k);
    cmd_addr = ad;
    cmd_exec = ex;
    cmd_data = d;
    while (cmd_ready !== 1'b1 && n < 50) begin @(negedge clk_in); n++; end
    @(negedge clk_in);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 100) begin @(negedge clk_in); n++; end
    if (n >= 50) begin n_errors++; stop_test(); end
    @(negedge clk_in);
  endtask : cmd
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    cmd(3'h0, {9'h000, ad}, 17'h0_0000, d);
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    cmd(3'h1, {9'h000, ad}, 17'h0_0000, 8'h00);
    check(17'(rsp_data), 17'(exp));
  endtask : rd
  task automatic acc(input logic [2:0] k, input logic [16:0] ad, input logic [16:0] ex, input logic den);
    cmd(k, ad, ex, seed[7:0]);
    check(17'(rsp_denied), 17'(den));
    if (k == 3'h2) check(17'(rsp_data), den ? 17'(flash_guard_pkg::DENY_DATA) : 17'(ad[7:0] ^ 8'h5a));
  endtask : acc
  // ==========
  // Main sequence
  initial begin
    repeat (10) @(negedge clk_in);
    resetn_in = 1'b1;
    rd(8'h8f, 8'h00);
    rd(8'hb7, 8'h80);
    rd(8'h55, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(8'hb7, {2'b00, i[1:0], 4'h1});
      rd(8'hb7, {2'b00, i[1:0], 4'h1});
      check(17'(rtime), 17'(i[1:0]));
    end
    wr(8'h8f, 8'hff);
    rd(8'h8f, 8'h07);
    wr(8'hb6, 8'h40);
    wr(8'hb6, 8'h00);
    rd(8'hb6, 8'h40);
    acc(3'h3, 17'h0_0400, 17'h0_0100, 1'b0);
    check(17'({last_scr, last_both}), 17'h0_0003);
    wr(8'h8f, 8'h04);
    acc(3'h2, 17'h0_0080, 17'h1_0000, 1'b0);
    check(17'(last_scr), 17'h0_0001);
    wr(8'h8f, 8'h00);
    acc(3'h2, 17'h0_4000, 17'h1_0000, 1'b1);
    acc(3'h2, 17'h0_c000, 17'h1_0000, 1'b0);
    acc(3'h4, 17'h0_4000, 17'h1_0000, 1'b0);
    acc(3'h2, 17'h0_4000, 17'h0_0100, 1'b0);
    acc(3'h2, 17'h1_f900, 17'h0_0100, 1'b0);
    acc(3'h2, 17'h1_fc10, 17'h0_0100, 1'b1);
    acc(3'h3, 17'h0_1234, 17'h0_0100, 1'b0);
    check(17'(n_xram), 17'h0_0001);
    check(17'(x_addr), 17'h0_1234);
    check(17'(x_data), 17'(seed[7:0]));
    wr(8'h8f, 8'h01);
    acc(3'h3, 17'h0_5000, 17'h0_0100, 1'b0);
    check(17'(last_op), 17'(flash_guard_pkg::FL_PROG));
    check(17'(f_data), 17'(seed[7:0]));
    wr(8'h8f, 8'h03);
    s = n_starts;
    acc(3'h3, 17'h1_f900, 17'h0_0100, 1'b1);
    check(17'(n_starts - s), 17'h0_0000);
    acc(3'h3, 17'h0_5000, 17'h0_0100, 1'b0);
    check(17'(last_op), 17'(flash_guard_pkg::FL_ERASE));
    wr(8'hb7, 8'h00);
    check(17'(n_quiet), 17'h0_0002);
    acc(3'h3, 17'h0_5000, 17'h0_0100, 1'b1);
    for (int i = 0; i < 20; i++) begin
      seed = lfsr(seed);
      a = seed[16:0];
      e = seed[31:15];
      acc(3'h2, a, e, a >= 17'h1_fc00 || (e >= 17'h0_8000 && a < 17'h0_8000));
    end
    stop_test();
  end
endmodule : flash_access_guard_bench
